// ---- verilog/satc_pkg.sv ----
// Shared constants for the converter conversion-control block.
package satc_pkg;
  localparam int CLK_MHZ = 50;
  localparam int CLK_PERIOD_NS = 20;
  localparam int NUM_CH = 8;
  localparam int RES_BITS = 12;
  localparam int ADDR_BITS = 4;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 13;
  // Control word field positions, first bit on the wire is bit 15.
  localparam int CW_WRITE = 15;
  localparam int CW_REPEAT = 14;
  localparam int CW_CH0 = 13;
  localparam int CW_TEMP = 5;
  localparam int CW_EXTREF = 2;
  localparam int CW_AVG = 1;
  localparam int CW_PPD = 0;
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [3:0] TEMP_ADDR = 4'h8;
  localparam logic [11:0] SAR_FIRST = 12'h800;
  // Temperature measurement timing.
  localparam int TEMP_TOTAL_US = 100;
  localparam int TEMP_TOTAL_CYC = TEMP_TOTAL_US * CLK_MHZ;
  localparam int TEMP_STEP_CYC = 16;
  localparam int TEMP_CONV_CYC = RES_BITS * TEMP_STEP_CYC;
  localparam int TEMP_INT_CYC = TEMP_TOTAL_CYC - TEMP_CONV_CYC;
  // Power-down/reset pin pulse window; longest time rounds down, least rounds up.
  localparam int RST_PULSE_MIN_NS = 1;
  localparam int RST_PULSE_MAX_NS = 100;
  localparam int RST_PULSE_MIN_CYC = (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PULSE_MAX_CYC = RST_PULSE_MAX_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_INTEG = 2'b01,
    TS_CONV = 2'b11
  } satc_temp_state_t;
endpackage

// ---- verilog/satc_sar_if.sv ----
// Interface between the control logic and the successive-approximation register.
`timescale 1ns/100ps
interface satc_sar_if;
  logic start;
  logic step;
  logic comp;
  logic [11:0] trial;
  logic busy;
  logic done;
  logic [11:0] result;
  modport ctrl (output start, output step, output comp, input trial, input busy, input done, input result);
  modport sar (input start, input step, input comp, output trial, output busy, output done, output result);
endinterface

// ---- verilog/satc_sar.sv ----
// Successive-approximation register that resolves one bit per step.
`timescale 1ns/100ps
module satc_sar (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  satc_sar_if.sar s
);
  logic [11:0] code_q;
  logic [11:0] mask_q;
  logic done_q;
  wire [11:0] kept = s.comp ? code_q : (code_q & ~mask_q);
  wire [11:0] next_mask = mask_q >> 1;

  // Each step keeps or drops the bit under trial, then tries the next lower one.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      code_q <= 12'h000;
      mask_q <= 12'h000;
      done_q <= 1'b0;
    end
    else if (i_ce)
    begin
      done_q <= 1'b0;
      if (s.start)
      begin
        code_q <= satc_pkg::SAR_FIRST;
        mask_q <= satc_pkg::SAR_FIRST;
      end
      else if (s.step && mask_q != 12'h000)
      begin
        code_q <= kept | next_mask;
        mask_q <= next_mask;
        done_q <= (next_mask == 12'h000);
      end
    end
  end

  assign s.trial = code_q;
  assign s.busy = (mask_q != 12'h000);
  assign s.done = done_q;
  assign s.result = code_q;

  AST_SAR_FIRST: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce)
    s.start |=> (code_q == 12'h800) && s.busy) else $error("SAR did not begin at mid-scale.");
endmodule

// ---- verilog/satc_ctrl.sv ----
// Conversion control: frame handling, sequencer, temperature timing and power states.
`timescale 1ns/100ps
// Overview of operation
// - A conversion result is shifted out in the transfer after its conversion.
// - In repeat mode each voltage-start chip-select fall moves to the next selected channel of eight; otherwise the first selected after channel 0.
// - The host serial clock shifts data and steps the voltage conversion.
// - Voltage results are straight binary; temperature results are twos complement.
// - Voltage codes run 0 to 4095, one code per reference step.
// - Temperature runs integration then conversion; integration starts at chip-select fall.
// - Integration plus conversion of temperature takes about 100 microseconds.
// - Temperature conversion starts by itself when integration ends.
// - Temperature busy is high from integration start until conversion ends.
// - Temperature codes are signed quarter degrees, minus 2048 to plus 2047.
// - Setting the temperature select bit makes the device measure temperature.
// - Partial power-down bit and power-down pin choose the power state.
// - Track-and-hold returns to tracking at the end of each conversion.
// - Chip-select fall holds the input and starts conversion; low enables output.
// - Frame holds four address bits then twelve result bits, MSB first.
// - Control bits on the serial input are captured on falling clock edges.
// - A short low reset pulse resets; a longer low level powers down.
module satc_ctrl #(
  parameter int P_TEMP_INT_CYC = satc_pkg::TEMP_INT_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_CS_N,
  input wire logic I_SCLK,
  input wire logic I_DIN,
  input wire logic I_POWERDOWN_RESET_PIN_N,
  input wire logic I_COMP,
  output logic O_DOUT,
  output logic O_DOUT_OE,
  output logic O_TEMP_BUSY_OUT,
  output logic O_HOLD,
  output logic O_TEMP_SOURCE,
  output logic [3:0] O_MUX_CH,
  output logic [11:0] O_DAC_CODE,
  output logic O_EXT_REF,
  output logic O_PARTIAL_PD,
  output logic O_FULL_PD
);
  satc_sar_if sar_bus ();

  logic [2:0] cs_sync_q, sclk_sync_q, pd_sync_q;
  logic [1:0] din_sync_q;
  logic soft_rst_q;
  logic [15:0] ctrl_q, cw_shift_q, out_q, result_q;
  logic [4:0] bit_cnt_q;
  logic [2:0] ch_q;
  logic conv_temp_q, out_now_q, full_pd_q;
  logic [satc_pkg::CNT_W-1:0] tcnt_q, pd_cnt_q;
  satc_pkg::satc_temp_state_t tstate_q;

  wire rst_all = I_RST | soft_rst_q;
  satc_sar u_sar (.i_clk(I_REF_CLK), .i_rst(rst_all), .i_ce(I_CE), .s(sar_bus.sar));

  // Pins come from outside the clock domain, so each passes two flops before use.
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      cs_sync_q <= 3'h7;
      sclk_sync_q <= 3'h7;
      pd_sync_q <= 3'h7;
      din_sync_q <= 2'h0;
    end
    else if (I_CE)
    begin
      cs_sync_q <= {cs_sync_q[1:0], I_CS_N};
      sclk_sync_q <= {sclk_sync_q[1:0], I_SCLK};
      pd_sync_q <= {pd_sync_q[1:0], I_POWERDOWN_RESET_PIN_N};
      din_sync_q <= {din_sync_q[0], I_DIN};
    end
  end

  // Edge decode looks only at the second and third stages.
  wire cs_low = ~cs_sync_q[1];
  wire cs_fall = cs_sync_q[2] & ~cs_sync_q[1];
  wire cs_rise = ~cs_sync_q[2] & cs_sync_q[1];
  wire sclk_fall = sclk_sync_q[2] & ~sclk_sync_q[1];
  wire pd_low = ~pd_sync_q[1];
  wire pd_rise = ~pd_sync_q[2] & pd_sync_q[1];
  wire frame_edge = cs_low & sclk_fall;

  // Channel decode: CH0 sits at the top of the channel field.
  wire [7:0] ch_mask;
  genvar gi;
  generate
    for (gi = 0; gi < satc_pkg::NUM_CH; gi++)
    begin : g_chmask
      assign ch_mask[gi] = ctrl_q[satc_pkg::CW_CH0 - gi];
    end
  endgenerate

  // Next selected channel after the current one in repeat mode, else after channel 0, wrapping round the eight inputs.
  function automatic logic [2:0] next_sel(input logic [7:0] m, input logic [2:0] cur, input logic rep);
    logic [2:0] pick;
    logic [2:0] idx;
    logic found;
    pick = cur;
    found = 1'b0;
    for (int k = 1; k <= 8; k++)
    begin
      idx = rep ? 3'(cur + 3'(k)) : 3'(k);
      if (!found && m[idx])
      begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  wire temp_sel = ctrl_q[satc_pkg::CW_TEMP];
  wire [2:0] next_ch = next_sel(ch_mask, ch_q, ctrl_q[satc_pkg::CW_REPEAT]);
  wire volt_start = cs_fall & ~temp_sel & ~sar_bus.busy & ~full_pd_q;
  wire temp_start = cs_fall & temp_sel & (tstate_q == satc_pkg::TS_IDLE) & ~full_pd_q;
  wire integ_end = (tstate_q == satc_pkg::TS_INTEG) && (tcnt_q == satc_pkg::CNT_W'(P_TEMP_INT_CYC - 1));
  wire temp_tick = (tstate_q == satc_pkg::TS_CONV) && (tcnt_q == satc_pkg::CNT_W'(satc_pkg::TEMP_STEP_CYC - 1));
  wire [11:0] temp_code = {~sar_bus.result[11], sar_bus.result[10:0]};
  wire cw_take = cs_rise & (bit_cnt_q == 5'(satc_pkg::FRAME_BITS)) & cw_shift_q[satc_pkg::CW_WRITE];

  // SAR is stepped by the serial clock for voltages and by a timer for temperature.
  assign sar_bus.start = volt_start | integ_end;
  assign sar_bus.step = conv_temp_q ? temp_tick : frame_edge;
  assign sar_bus.comp = I_COMP;

  // Control word capture on falling serial edges; only the first sixteen count.
  always_ff @(posedge I_REF_CLK)
  begin
    if (rst_all)
    begin
      cw_shift_q <= satc_pkg::CW_RESET;
      bit_cnt_q <= 5'h00;
      ctrl_q <= satc_pkg::CW_RESET;
    end
    else if (I_CE)
    begin
      if (cs_fall)
        bit_cnt_q <= 5'h00;
      else if (frame_edge && bit_cnt_q != 5'(satc_pkg::FRAME_BITS))
      begin
        cw_shift_q <= {cw_shift_q[14:0], din_sync_q[1]};
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (cw_take)
        ctrl_q <= cw_shift_q;
    end
  end

  // Output frame loads last result at chip-select fall and shifts on falling edges.
  always_ff @(posedge I_REF_CLK)
  begin
    if (rst_all)
    begin
      out_q <= satc_pkg::RESULT_RESET;
      ch_q <= 3'h0;
      conv_temp_q <= 1'b0;
    end
    else if (I_CE)
    begin
      if (cs_fall)
        out_q <= result_q;
      else if (frame_edge)
        out_q <= {out_q[14:0], 1'b0};
      if (volt_start)
      begin
        ch_q <= next_ch;
        conv_temp_q <= 1'b0;
      end
      else if (integ_end)
        conv_temp_q <= 1'b1;
    end
  end

  // Result store: address nibble over the coded twelve-bit value.
  always_ff @(posedge I_REF_CLK)
  begin
    if (rst_all)
      result_q <= satc_pkg::RESULT_RESET;
    else if (I_CE && sar_bus.done)
      result_q <= conv_temp_q ? {satc_pkg::TEMP_ADDR, temp_code} : {1'b0, ch_q, sar_bus.result};
  end

  // Temperature phases; the timer restarts at each phase change.
  always_ff @(posedge I_REF_CLK)
  begin
    if (rst_all)
    begin
      tstate_q <= satc_pkg::TS_IDLE;
      tcnt_q <= '0;
    end
    else if (I_CE)
    begin
      case (tstate_q)
        satc_pkg::TS_IDLE:
        begin
          tcnt_q <= '0;
          if (temp_start)
            tstate_q <= satc_pkg::TS_INTEG;
        end
        satc_pkg::TS_INTEG:
        begin
          tcnt_q <= integ_end ? '0 : tcnt_q + 1'b1;
          if (integ_end)
            tstate_q <= satc_pkg::TS_CONV;
        end
        satc_pkg::TS_CONV:
        begin
          tcnt_q <= temp_tick ? '0 : tcnt_q + 1'b1;
          if (sar_bus.done)
            tstate_q <= satc_pkg::TS_IDLE;
        end
        default: tstate_q <= satc_pkg::TS_IDLE;
      endcase
    end
  end

  // Power-down pin: a short low pulse is a reset, a long low level is full power-down.
  // Pulses shorter than one clock period may be missed by the sampler.
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      pd_cnt_q <= '0;
      full_pd_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end
    else if (I_CE)
    begin
      soft_rst_q <= pd_rise && pd_cnt_q >= satc_pkg::CNT_W'(satc_pkg::RST_PULSE_MIN_CYC)
        && pd_cnt_q <= satc_pkg::CNT_W'(satc_pkg::RST_PULSE_MAX_CYC);
      if (!pd_low)
        pd_cnt_q <= '0;
      else if (pd_cnt_q != '1)
        pd_cnt_q <= pd_cnt_q + 1'b1;
      full_pd_q <= pd_low && pd_cnt_q >= satc_pkg::CNT_W'(satc_pkg::RST_PULSE_MAX_CYC);
    end
  end

  // Outputs to the analog section and the serial pin.
  always_ff @(posedge I_REF_CLK)
  begin
    if (rst_all)
    begin
      O_DOUT <= 1'b0;
      O_TEMP_BUSY_OUT <= 1'b0;
      O_PARTIAL_PD <= 1'b0;
      out_now_q <= 1'b0;
    end
    else if (I_CE)
    begin
      O_DOUT <= out_q[15];
      out_now_q <= cs_low;
      O_TEMP_BUSY_OUT <= temp_start | (tstate_q != satc_pkg::TS_IDLE && !(sar_bus.done && conv_temp_q));
      O_PARTIAL_PD <= ctrl_q[satc_pkg::CW_PPD] & ~cs_low & ~sar_bus.busy & (tstate_q == satc_pkg::TS_IDLE);
    end
  end

  assign O_DOUT_OE = out_now_q;
  assign O_HOLD = sar_bus.busy;
  assign O_TEMP_SOURCE = conv_temp_q;
  assign O_MUX_CH = {1'b0, ch_q};
  assign O_DAC_CODE = sar_bus.trial;
  assign O_EXT_REF = ctrl_q[satc_pkg::CW_EXTREF];
  assign O_FULL_PD = full_pd_q;

  sequence seq_temp_go;
    temp_start ##1 (tstate_q == satc_pkg::TS_INTEG);
  endsequence
  sequence seq_busy_on;
    O_TEMP_BUSY_OUT;
  endsequence

  AST_BUSY_RISE: assert property (@(posedge I_REF_CLK) disable iff (rst_all || !I_CE)
    seq_temp_go |-> seq_busy_on) else $error("Temperature busy not high at integration start.");
  AST_INT_TO_CONV: assert property (@(posedge I_REF_CLK) disable iff (rst_all || !I_CE)
    integ_end |=> (tstate_q == satc_pkg::TS_CONV) && sar_bus.busy) else $error("Conversion did not follow integration.");
  AST_BUSY_IDLE: assert property (@(posedge I_REF_CLK) disable iff (rst_all || !I_CE)
    (tstate_q == satc_pkg::TS_IDLE) && $past(tstate_q == satc_pkg::TS_IDLE) && !$past(temp_start) |-> !O_TEMP_BUSY_OUT)
    else $error("Temperature busy high with no measurement.");
  AST_TRACK_AFTER: assert property (@(posedge I_REF_CLK) disable iff (rst_all || !I_CE)
    sar_bus.done |-> !O_HOLD) else $error("Track-and-hold not tracking after conversion.");
  AST_HOLD_ON_CS: assert property (@(posedge I_REF_CLK) disable iff (rst_all || !I_CE)
    volt_start |=> O_HOLD ##0 (ch_q == $past(next_ch))) else $error("Chip-select fall did not start conversion.");
  AST_LATENCY: assert property (@(posedge I_REF_CLK) disable iff (rst_all || !I_CE)
    cs_fall |=> out_q == $past(result_q)) else $error("Frame did not carry the previous result.");
  AST_SHIFT: assert property (@(posedge I_REF_CLK) disable iff (rst_all || !I_CE)
    frame_edge && !cs_fall |=> out_q == {$past(out_q[14:0]), 1'b0}) else $error("Output frame did not shift.");
  AST_TEMP_CODE: assert property (@(posedge I_REF_CLK) disable iff (rst_all || !I_CE)
    sar_bus.done && conv_temp_q |=> result_q == {satc_pkg::TEMP_ADDR, ~$past(sar_bus.result[11]), $past(sar_bus.result[10:0])})
    else $error("Temperature result not twos complement.");
endmodule

// ---- sim/satc_host_model.sv ----
// Serial host and analog front-end model facing the conversion-control block.
`timescale 1ns/100ps
module satc_host_model (
  input wire logic i_clk,
  input wire logic i_dout,
  input wire logic i_dout_oe,
  input wire logic i_hold,
  input wire logic i_temp_source,
  input wire logic [3:0] i_mux_ch,
  input wire logic [11:0] i_dac_code,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din,
  output logic o_comp
);
  logic [11:0] ain [8];
  logic [11:0] tcode;

  // Idle levels: chip select high and the serial clock parked high between frames.
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
  end

  // Comparator: registered so it never races the trial code it is judging.
  always @(posedge i_clk)
    o_comp <= i_temp_source ? (tcode >= i_dac_code) : (ain[i_mux_ch[2:0]] >= i_dac_code);

  // One 16-bit frame; the low phase is long so the output bit is settled well before it is taken.
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, output logic hold_seen,
                      output logic oe_seen);
    o_cs_n <= 1'b0;
    o_din <= tx[15];
    repeat (8) @(posedge i_clk);
    hold_seen = i_hold;
    oe_seen = i_dout_oe;
    for (int i = 15; i >= 0; i--)
    begin
      rx[i] = i_dout;
      o_sclk <= 1'b0;
      repeat (6) @(posedge i_clk);
      o_sclk <= 1'b1;
      o_din <= (i > 0) ? tx[(i > 0) ? i - 1 : 0] : 1'b0;
      repeat (2) @(posedge i_clk);
    end
    repeat (6) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_din <= ~o_din;
    repeat (12) @(posedge i_clk);
  endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking testbench for the conversion-control block.
`timescale 1ns/100ps
module tb;
  localparam int TINT = 50;
  localparam int TT = TINT + satc_pkg::TEMP_CONV_CYC;
  logic clk;
  logic rst;
  logic pin_n;
  logic cs_d;
  logic busy_d;
  logic src_seen = 1'b0;
  logic ce;
  logic [15:0] cur_cw;
  logic [15:0] exp_q;
  logic [2:0] ch;
  int err_total;
  int checks;
  int busy_hi;
  int cyc_cs;
  int busy_end;
  wire logic cs_n, sclk, din, comp, dout, dout_oe, busy, hold, tsrc, ext_ref, partial_powerdown_bit, fpd;
  wire logic [3:0] mux_ch;
  wire logic [11:0] dac;

  satc_ctrl #(.P_TEMP_INT_CYC(TINT)) i_dut (.I_REF_CLK(clk), .I_RST(rst), .I_CE(ce), .I_CS_N(cs_n),
    .I_SCLK(sclk), .I_DIN(din), .I_POWERDOWN_RESET_PIN_N(pin_n), .I_COMP(comp), .O_DOUT(dout),
    .O_DOUT_OE(dout_oe), .O_TEMP_BUSY_OUT(busy), .O_HOLD(hold), .O_TEMP_SOURCE(tsrc), .O_MUX_CH(mux_ch),
    .O_DAC_CODE(dac), .O_EXT_REF(ext_ref), .O_PARTIAL_PD(partial_powerdown_bit), .O_FULL_PD(fpd));

  satc_host_model i_host (.i_clk(clk), .i_dout(dout), .i_dout_oe(dout_oe), .i_hold(hold),
    .i_temp_source(tsrc), .i_mux_ch(mux_ch), .i_dac_code(dac), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_din(din), .o_comp(comp));

  // Busy monitor: total high time and the span from chip-select fall to busy fall.
  always @(posedge clk)
  begin
    cs_d <= cs_n;
    busy_d <= busy;
    cyc_cs <= (cs_d && !cs_n) ? 0 : cyc_cs + 1;
    if (busy)
      busy_hi <= busy_hi + 1;
    if (busy_d && !busy)
      busy_end <= cyc_cs;
    if (tsrc)
      src_seen <= 1'b1;
  end

  // Next channel: lowest offset after the base wins; no selection keeps the channel.
  function automatic logic [2:0] next_ch(input logic [2:0] c, input logic [15:0] cw);
    logic [2:0] base;
    logic [2:0] n;
    next_ch = c;
    base = cw[14] ? c : 3'h0;
    for (int k = 8; k >= 1; k--)
    begin
      n = base + 3'(k);
      if (cw[13 - n])
        next_ch = n;
    end
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One frame: the result shown is the previous conversion, then this one becomes the next expectation.
  task automatic do_frame(input logic [15:0] tx, input logic vchk);
    logic [15:0] rx;
    logic h;
    logic oe;
    ch = next_ch(ch, cur_cw);
    i_host.xfer(tx, rx, h, oe);
    chk(rx, exp_q);
    chk(oe, 1'b1);
    chk(dout_oe, 1'b0);
    if (vchk)
    begin
      chk(h, 1'b1);
      chk(hold, 1'b0);
      chk(mux_ch, {1'b0, ch});
      chk(dac, i_host.ain[ch]);
    end
    exp_q = {1'b0, ch, i_host.ain[ch]};
    if (tx[15])
      cur_cw = tx;
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard, sized well above the few thousand cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial
  begin
    logic [15:0] tx;
    logic [11:0] tv [3];
    int b0;
    void'($urandom(32'hacd00a1a));
    rst = 1'b1;
    pin_n = 1'b1;
    ce = 1'b1;
    cur_cw = satc_pkg::CW_RESET;
    exp_q = satc_pkg::RESULT_RESET;
    ch = 3'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(busy, 1'b0);
    // Random sequences, with an all-zero and a full-scale frame first.
    for (int f = 0; f < 24; f++)
    begin
      for (int k = 0; k < 8; k++)
        i_host.ain[k] = (f == 0) ? 12'h000 : (f == 1) ? 12'hfff : 12'($urandom);
      tx = 16'($urandom) & 16'hffc5;
      if (f < 2)
        tx[15] = 1'b1;
      if (tx[13:6] == 8'h00)
        tx[13:6] = 8'h81;
      do_frame(tx, 1'b1);
      chk(partial_powerdown_bit, cur_cw[0]);
      chk(ext_ref, cur_cw[2]);
    end
    chk(16'(busy_hi), 16'h0000);
    // Temperature at both range ends and one negative reading; channel 3 only.
    tv = '{12'h800, 12'h7ff, 12'hf60};
    foreach (tv[j])
    begin
      b0 = busy_hi;
      i_host.tcode = tv[j] ^ 12'h800;
      do_frame(16'hc420, 1'b1);
      do_frame(16'hc400, 1'b0);
      chk(busy, 1'b1);
      for (int w = 0; w < 400 && busy !== 1'b0; w++)
        @(posedge clk);
      repeat (2) @(posedge clk);
      chk(busy, 1'b0);
      chk(busy_hi - b0 >= TT - 1 && busy_hi - b0 <= TT + 4, 1'b1);
      chk(busy_end >= TT + 2 && busy_end <= TT + 9, 1'b1);
      chk(src_seen, 1'b1);
      exp_q = {satc_pkg::TEMP_ADDR, tv[j]};
      do_frame(16'hc400, 1'b1);
    end
    // Long low level powers down, a short pulse resets; with the clock enable low nothing moves.
    ce <= 1'b0;
    pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk(fpd, 1'b0);
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    chk(fpd, 1'b1);
    pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(fpd, 1'b0);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    cur_cw = satc_pkg::CW_RESET;
    exp_q = satc_pkg::RESULT_RESET;
    ch = 3'h0;
    do_frame(16'h0000, 1'b1);
    do_frame(16'h0000, 1'b1);
    print_verdict();
  end
endmodule
